// ---- shared/jpm_pkg.sv ----
// Constants shared by the channel 0 jitter peak measurement block.
// Assumes a 125 MHz system clock and word-aligned APB register access.
package jpm_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 13;         // APB byte address width
   localparam int          IDX_W         = 11;         // Register index width
   localparam logic [10:0] IDX_TALLY_MASK = 11'h020;   // Interrupt mask
   localparam logic [10:0] IDX_TALLY_CTRL = 11'h021;   // Tally update control
   localparam logic [10:0] IDX_TALLY_STAT = 11'h022;   // Interrupt status, write one to clear
   localparam logic [10:0] IDX_ERR_LOW    = 11'h023;   // error_tally_low
   localparam logic [10:0] IDX_ERR_HIGH   = 11'h024;   // error_tally_high
   localparam logic [10:0] IDX_JM_CFG     = 11'h7E5;   // jitter_measure_config
   localparam logic [10:0] IDX_POS_LOW    = 11'h7E6;   // positive_peak_low
   localparam logic [10:0] IDX_POS_HIGH   = 11'h7E7;   // positive_peak_high
   localparam logic [10:0] IDX_NEG_LOW    = 11'h7E8;   // negative_peak_low
   localparam logic [10:0] IDX_NEG_HIGH   = 11'h7E9;   // negative_peak_high
   localparam logic [1:0]  WORD_ALIGN     = 2'h0;      // Low address bits of a legal access

   // ----------------------------------------------------------------
   // Field layout and reset values
   // ----------------------------------------------------------------
   localparam int          BIT_BAND_SEL   = 0;         // band_select
   localparam int          BIT_PERIOD_SEL = 1;         // period_select
   localparam int          BIT_END_TRIG   = 2;         // period_end_trigger
   localparam int          JM_W           = 3;         // Implemented config bits
   localparam int          BIT_TALLY_TRIG = 0;         // Manual tally update trigger
   localparam int          BIT_TALLY_SEL  = 1;         // tally_update_select
   localparam int          BIT_TALLY_OVF  = 0;         // tally_overflow_flag
   localparam logic [2:0]  JM_RESET       = 3'h0;      // Config after reset
   localparam logic [1:0]  TCTRL_RESET    = 2'h0;      // Tally control after reset
   localparam int          PEAK_W         = 12;        // Peak code width, 1/16 UIpp per step
   localparam int          TALLY_W        = 16;        // Error tally width
   localparam int          BYTE_W         = 8;         // Register data width

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint      CLK_HZ         = 125000000; // System clock rate
   localparam longint      PERIOD_MS      = 1000;      // Automatic period, milliseconds
   localparam int          PERIOD_CYC     = int'(CLK_HZ / 1000 * PERIOD_MS);
endpackage : jpm_pkg

// ---- hw/jpm_top.sv ----
// Channel 0 jitter peak capture, error tally high/low byte and overflow interrupt.
// Assumes jitter magnitudes and error events come from logic on I_CLK, and an APB master.
`timescale 1ns/1ps
`default_nettype none

// Function
// (RQ1) Error tally high byte readable, read only
// (RQ2) Error tally high byte zero after reset
// (RQ3) Config: trigger bit2, period bit1, band bit0
// (RQ4) Trigger rising edge loads both peak results
// (RQ5) Software clears trigger before next capture
// (RQ6) Manual mode: period ends only on trigger
// (RQ7) Automatic mode: period ends every second
// (RQ8) Band zero selects wide low-frequency filter
// (RQ9) Band one selects high-frequency filter band
// (RQ10) Hold greatest positive peak, twelve bits
// (RQ11) Positive result updates per period select
// (RQ12) Software reads results before next update
// (RQ13) Peak code counts sixteenths of UIpp
// (RQ14) Positive peak low byte zero after reset
// (RQ15) Trigger ignored in automatic mode
// (RQ16) Tally accumulates; update overwrites result registers
// (RQ17) Tally overflow sets write-one-clear flag
// (RQ18) Negative peak captured like positive peak
module jpm_top #(
   parameter int P_PERIOD_CYC = jpm_pkg::PERIOD_CYC   // Cycles in one automatic period
) (
   input  wire  logic                        I_CLK,          // System clock
   input  wire  logic                        I_RESETN,       // Async reset, active low
   input  wire  logic                        I_PSEL,         // APB select
   input  wire  logic                        I_PENABLE,      // APB access phase
   input  wire  logic                        I_PWRITE,       // APB direction
   input  wire  logic [jpm_pkg::ADDR_W-1:0]  I_PADDR,        // APB byte address
   input  wire  logic [31:0]                 I_PWDATA,       // APB write data
   output logic       [31:0]                 O_PRDATA,       // APB read data
   output logic                              O_PREADY,       // APB ready
   output logic                              O_PSLVERR,      // APB error, unmapped or misaligned address
   input  wire  logic                        I_SAMPLE_VLD,   // Demodulated sample valid
   input  wire  logic [jpm_pkg::PEAK_W-1:0]  I_POS_SWING,    // Positive swing magnitude
   input  wire  logic [jpm_pkg::PEAK_W-1:0]  I_NEG_SWING,    // Negative swing magnitude
   input  wire  logic                        I_ERR_EVENT,    // One error counted per cycle high
   output logic                              O_BAND_SELECT,  // Filter band to front end
   output logic                              O_PERIOD_END,   // Pulse when results update
   output logic                              O_IRQ           // Level interrupt
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int CW = $clog2(P_PERIOD_CYC + 1);
   localparam logic [CW-1:0] TICK_LAST = CW'(P_PERIOD_CYC - 1);  // Last count of a period

   logic [jpm_pkg::IDX_W-1:0]   idx;             // Register index of the access
   logic                        aligned;         // Word aligned access
   logic                        setup;           // APB setup cycle
   logic                        wr_en;           // Write takes effect this edge
   logic                        hit;             // Address is mapped and word aligned
   logic [7:0]                  rd_byte;         // Selected register contents
   logic [CW-1:0]               tick_cnt_q;      // Period counter
   logic                        tick;            // One-second enable
   logic [jpm_pkg::JM_W-1:0]    jm_q;            // Measurement config
   logic                        trig_rise;       // Trigger written 0 to 1
   logic                        jit_cap;         // End of a jitter period
   logic [jpm_pkg::PEAK_W-1:0]  pos_max_q;       // Running positive maximum
   logic [jpm_pkg::PEAK_W-1:0]  neg_max_q;       // Running negative maximum
   logic [jpm_pkg::PEAK_W-1:0]  pos_now;         // Maximum including this sample
   logic [jpm_pkg::PEAK_W-1:0]  neg_now;         // Maximum including this sample
   logic [jpm_pkg::PEAK_W-1:0]  pos_res_q;       // positive_swing_peak result
   logic [jpm_pkg::PEAK_W-1:0]  neg_res_q;       // negative_swing_peak result
   logic [1:0]                  tctrl_q;         // Tally update control
   logic                        tally_rise;      // Manual tally trigger 0 to 1
   logic                        tally_upd;       // Tally result update
   logic [jpm_pkg::TALLY_W-1:0] tally_cnt_q;     // Internal error accumulator
   logic [jpm_pkg::TALLY_W-1:0] tally_res_q;     // error_tally result
   logic                        ovf;             // Error event while accumulator is all ones
   logic                        stat_q;          // tally_overflow_flag
   logic                        mask_q;          // Interrupt mask, one enables

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign idx     = I_PADDR[jpm_pkg::ADDR_W-1:2];
   assign aligned = (I_PADDR[1:0] == jpm_pkg::WORD_ALIGN);
   assign setup   = I_PSEL & ~I_PENABLE;
   assign wr_en   = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & ~O_PSLVERR;

   // Read multiplexer; narrow registers sit in the low bits
   always_comb begin
      hit     = aligned;
      rd_byte = 8'h00;
      unique case (idx)
         jpm_pkg::IDX_TALLY_MASK : rd_byte = {7'h00, mask_q};
         jpm_pkg::IDX_TALLY_CTRL : rd_byte = {6'h00, tctrl_q};
         jpm_pkg::IDX_TALLY_STAT : rd_byte = {7'h00, stat_q};
         jpm_pkg::IDX_ERR_LOW    : rd_byte = tally_res_q[7:0];
         jpm_pkg::IDX_ERR_HIGH   : rd_byte = tally_res_q[15:8];           // [RQ1]
         jpm_pkg::IDX_JM_CFG     : rd_byte = {5'h00, jm_q};               // [RQ3]
         jpm_pkg::IDX_POS_LOW    : rd_byte = pos_res_q[7:0];              // [RQ10]
         jpm_pkg::IDX_POS_HIGH   : rd_byte = {4'h0, pos_res_q[11:8]};     // [RQ10]
         jpm_pkg::IDX_NEG_LOW    : rd_byte = neg_res_q[7:0];              // [RQ18]
         jpm_pkg::IDX_NEG_HIGH   : rd_byte = {4'h0, neg_res_q[11:8]};     // [RQ18]
         default                 : hit = 1'b0;
      endcase
   end

   // Answer in the first access cycle; data and error registered in setup
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= setup;
         O_PSLVERR <= setup & ~hit;
         // Read data only for mapped reads
         if (setup && hit && !I_PWRITE) begin
            O_PRDATA <= {24'h00_0000, rd_byte};
         end else begin
            O_PRDATA <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // One-second timebase
   // ----------------------------------------------------------------
   assign tick = (tick_cnt_q == TICK_LAST);

   // Free-running period counter
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         tick_cnt_q <= '0;
      end else if (tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Jitter measurement configuration
   // ----------------------------------------------------------------
   // Trigger stays set until software writes zero; only 0 to 1 acts
   assign trig_rise = wr_en && (idx == jpm_pkg::IDX_JM_CFG)
                      && I_PWDATA[jpm_pkg::BIT_END_TRIG] && !jm_q[jpm_pkg::BIT_END_TRIG]; // [RQ5]
   // Period end: timebase in automatic mode, trigger in manual mode
   assign jit_cap   = jm_q[jpm_pkg::BIT_PERIOD_SEL] ? tick : trig_rise;       // [RQ6] [RQ7] [RQ15]

   // Config register, reserved bits not stored
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         jm_q <= jpm_pkg::JM_RESET;
      end else if (wr_en && idx == jpm_pkg::IDX_JM_CFG) begin
         jm_q <= I_PWDATA[jpm_pkg::JM_W-1:0];                              // [RQ3]
      end
   end

   // Band choice drives the front-end filter: 0 wide, 1 high band
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_BAND_SELECT <= 1'b0;
      end else begin
         O_BAND_SELECT <= jm_q[jpm_pkg::BIT_BAND_SEL];                    // [RQ8] [RQ9]
      end
   end

   // ----------------------------------------------------------------
   // Peak tracking and capture
   // ----------------------------------------------------------------
   // Codes are kept unscaled: one step is 1/16 UIpp [RQ13]
   always_comb begin
      pos_now = pos_max_q;
      neg_now = neg_max_q;
      if (I_SAMPLE_VLD && I_POS_SWING > pos_max_q) begin
         pos_now = I_POS_SWING;
      end
      if (I_SAMPLE_VLD && I_NEG_SWING > neg_max_q) begin
         neg_now = I_NEG_SWING;
      end
   end

   // Running maxima restart at each period end with the current sample
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         pos_max_q <= '0;
         neg_max_q <= '0;
      end else if (jit_cap) begin
         pos_max_q <= I_SAMPLE_VLD ? I_POS_SWING : '0;
         neg_max_q <= I_SAMPLE_VLD ? I_NEG_SWING : '0;
      end else begin
         pos_max_q <= pos_now;                                              // [RQ10]
         neg_max_q <= neg_now;                                              // [RQ18]
      end
   end

   // Result registers; previous value overwritten at each period end
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         pos_res_q <= '0;                                                   // [RQ14]
         neg_res_q <= '0;
      end else if (jit_cap) begin
         pos_res_q <= pos_now;                                              // [RQ4] [RQ11]
         neg_res_q <= neg_now;                                              // [RQ4] [RQ18]
      end
   end

   // Pulse flags a fresh result set
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_PERIOD_END <= 1'b0;
      end else begin
         O_PERIOD_END <= jit_cap;
      end
   end

   // ----------------------------------------------------------------
   // Error tally
   // ----------------------------------------------------------------
   assign tally_rise = wr_en && (idx == jpm_pkg::IDX_TALLY_CTRL)
                       && I_PWDATA[jpm_pkg::BIT_TALLY_TRIG] && !tctrl_q[jpm_pkg::BIT_TALLY_TRIG];
   assign tally_upd  = tctrl_q[jpm_pkg::BIT_TALLY_SEL] ? tick : tally_rise;
   assign ovf        = I_ERR_EVENT && (tally_cnt_q == {jpm_pkg::TALLY_W{1'b1}});

   // Tally control register
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         tctrl_q <= jpm_pkg::TCTRL_RESET;
      end else if (wr_en && idx == jpm_pkg::IDX_TALLY_CTRL) begin
         tctrl_q <= I_PWDATA[1:0];
      end
   end

   // Accumulator restarts after each update; event on that edge kept
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         tally_cnt_q <= '0;
      end else if (tally_upd) begin
         tally_cnt_q <= {{(jpm_pkg::TALLY_W-1){1'b0}}, I_ERR_EVENT};
      end else if (I_ERR_EVENT) begin
         tally_cnt_q <= tally_cnt_q + 1'b1;                                 // [RQ16]
      end
   end

   // Result seen by software through low and high byte
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         tally_res_q <= '0;                                                 // [RQ2]
      end else if (tally_upd) begin
         tally_res_q <= tally_cnt_q;                                        // [RQ16]
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------------------------------
   // Sticky flag; a set in the clearing cycle wins
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         stat_q <= 1'b0;
      end else begin
         stat_q <= ovf | (stat_q & ~(wr_en && idx == jpm_pkg::IDX_TALLY_STAT
                                     && I_PWDATA[jpm_pkg::BIT_TALLY_OVF])); // [RQ17]
      end
   end

   // Mask register and level interrupt
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         mask_q <= 1'b0;
         O_IRQ  <= 1'b0;
      end else begin
         if (wr_en && idx == jpm_pkg::IDX_TALLY_MASK) begin
            mask_q <= I_PWDATA[0];
         end
         O_IRQ <= stat_q & mask_q;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   AST_HIGH_BYTE_READ: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ1]
      (setup && !I_PWRITE && aligned && idx == jpm_pkg::IDX_ERR_HIGH)
      |=> O_PREADY && O_PRDATA == {24'h00_0000, $past(tally_res_q[15:8])})
      else $error("Tally high byte read returned wrong data");

   AST_HIGH_BYTE_RESET: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ2]
      $rose(I_RESETN) |-> tally_res_q == '0)
      else $error("Tally result not zero after reset");

   AST_CFG_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ3]
      (wr_en && idx == jpm_pkg::IDX_JM_CFG) |=> jm_q == $past(I_PWDATA[2:0]))
      else $error("Config write not stored");

   AST_MANUAL_CAPTURE: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ4]
      (trig_rise && !jm_q[jpm_pkg::BIT_PERIOD_SEL])
      |=> pos_res_q == $past(pos_now) && neg_res_q == $past(neg_now) && O_PERIOD_END
      ##1 !O_PERIOD_END)
      else $error("Manual trigger did not load both peaks");

   AST_MANUAL_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ6]
      (!jm_q[jpm_pkg::BIT_PERIOD_SEL] && !trig_rise) |=> $stable(pos_res_q) && !O_PERIOD_END)
      else $error("Result changed without trigger in manual mode");

   AST_AUTO_SECOND: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ7]
      (tick && jm_q[jpm_pkg::BIT_PERIOD_SEL]) |=> pos_res_q == $past(pos_now) && O_PERIOD_END)
      else $error("Automatic period end did not update result");

   AST_AUTO_IGNORE_TRIG: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ15]
      (jm_q[jpm_pkg::BIT_PERIOD_SEL] && !tick) |=> $stable(neg_res_q))
      else $error("Trigger acted in automatic mode");

   AST_TALLY_UPDATE: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ16]
      tally_upd |=> tally_res_q == $past(tally_cnt_q) && tally_cnt_q <= 16'h0001)
      else $error("Tally update wrong");

   AST_OVF_FLAG: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ17]
      ovf |=> stat_q)
      else $error("Overflow did not raise flag");

   AST_IRQ_LEVEL: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // [RQ17]
      1'b1 |=> O_IRQ == $past(stat_q && mask_q))
      else $error("Interrupt does not follow unmasked flag");
endmodule : jpm_top

`default_nettype wire

// ---- tb/jpm_top_bench.sv ----
// Self-checking bench for the jitter peak capture and error tally block.
// Assumes the jpm_pkg constants; drives APB, samples and error events itself.
`timescale 1ns/1ps
`default_nettype none
module jpm_top_bench;
   // ----------------------------------------------------------------
   // Stimulus signals
   // ----------------------------------------------------------------
   logic        clk;          // System clock, 8 ns
   logic        rst_n;        // Async reset, active low
   logic        psel;         // APB select
   logic        pen;          // APB access phase
   logic        pwr;          // APB direction
   logic [12:0] paddr;        // APB byte address
   logic [31:0] pwdata;       // APB write data
   logic [31:0] prdata;       // APB read data
   logic        pready;       // APB ready
   logic        pslverr;      // APB error
   logic        vld;          // Sample valid
   logic [11:0] pos;          // Positive swing
   logic [11:0] neg;          // Negative swing
   logic        ev;           // Error event
   logic        band;         // Band select out
   logic        pend;         // Period end pulse
   logic        irq;          // Interrupt
   int          error_cnt;    // Mismatches
   int          checks;       // Comparisons
   int          n;            // Cycle count scratch
   localparam int P_CYC = 50; // Short automatic period for simulation
   jpm_top #(.P_PERIOD_CYC(P_CYC)) jpm_top_i (
      .I_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_SAMPLE_VLD(vld), .I_POS_SWING(pos), .I_NEG_SWING(neg),
      .I_ERR_EVENT(ev), .O_BAND_SELECT(band), .O_PERIOD_END(pend), .O_IRQ(irq));
   // ----------------------------------------------------------------
   // Compare tasks and closing
   // ----------------------------------------------------------------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_bit(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask : chk_bit
   task automatic end_sim;
      if (error_cnt == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   // ----------------------------------------------------------------
   // APB master: setup, access held until ready seen, then release
   // ----------------------------------------------------------------
   task automatic apb(input logic wr, input logic [10:0] idx, input logic [1:0] lo,
                      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int k;
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= wr;
      paddr  <= {idx, lo};
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      // Ready is taken at a rising edge; the wait has no limit of its own, so only the watchdog ends a hung one
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      chk_bit(k < 20, 1'b1);
   endtask : apb
   task automatic wr(input logic [10:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, idx, 2'h0, d, r, e);
      chk_bit(e, 1'b0);
   endtask : wr
   task automatic rd(input logic [10:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, idx, 2'h0, 32'h0, r, e);
      chk_reg(r, exp);
      chk_bit(e, 1'b0);
   endtask : rd
   // One demodulated sample for one cycle
   task automatic smp(input logic [11:0] p, input logic [11:0] q);
      @(posedge clk);
      vld <= 1'b1;
      pos <= p;
      neg <= q;
      @(posedge clk);
      vld <= 1'b0;
   endtask : smp
   // Counts cycles up to the next period end pulse, bounded
   task automatic wait_pe(output int c);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (pend !== 1'b1 && c < 1000);
      chk_bit(c < 1000, 1'b1);
   endtask : wait_pe
   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #(8 * 80000);
      error_cnt++;
      end_sim();
   end
   initial begin
      logic [31:0] r;
      logic        e;
      error_cnt = 0;
      checks = 0;
      rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 13'h0000;
      pwdata = 32'h0; vld = 1'b0; pos = 12'h000; neg = 12'h000; ev = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values
      rd(jpm_pkg::IDX_ERR_HIGH, 32'h00);
      rd(jpm_pkg::IDX_POS_LOW, 32'h00);
      rd(jpm_pkg::IDX_JM_CFG, 32'h00);
      chk_bit(irq, 1'b0);
      // Manual capture holds the largest swing of the period
      smp(12'h5A3, 12'h0C4);
      smp(12'h2B0, 12'h7E1);
      wr(jpm_pkg::IDX_JM_CFG, 32'h4);
      rd(jpm_pkg::IDX_POS_LOW, 32'hA3);
      rd(jpm_pkg::IDX_POS_HIGH, 32'h05);
      rd(jpm_pkg::IDX_NEG_LOW, 32'hE1);
      rd(jpm_pkg::IDX_NEG_HIGH, 32'h07);
      // Trigger already set: no new capture until written back to zero
      smp(12'hFFF, 12'h801);
      wr(jpm_pkg::IDX_JM_CFG, 32'h4);
      rd(jpm_pkg::IDX_POS_LOW, 32'hA3);
      wr(jpm_pkg::IDX_JM_CFG, 32'hF8);
      rd(jpm_pkg::IDX_JM_CFG, 32'h00);
      wr(jpm_pkg::IDX_JM_CFG, 32'h5);
      rd(jpm_pkg::IDX_POS_LOW, 32'hFF);
      rd(jpm_pkg::IDX_POS_HIGH, 32'h0F);
      rd(jpm_pkg::IDX_NEG_HIGH, 32'h08);
      rd(jpm_pkg::IDX_JM_CFG, 32'h05);
      chk_bit(band, 1'b1);
      // Automatic mode: fixed spacing, trigger ignored
      wr(jpm_pkg::IDX_JM_CFG, 32'h2);
      repeat (2) @(posedge clk);
      chk_bit(band, 1'b0);
      wait_pe(n);
      wait_pe(n);
      chk_reg(n, P_CYC);
      smp(12'h0AB, 12'h00C);
      wr(jpm_pkg::IDX_JM_CFG, 32'h6);
      rd(jpm_pkg::IDX_POS_LOW, 32'h00);
      wait_pe(n);
      rd(jpm_pkg::IDX_POS_LOW, 32'hAB);
      rd(jpm_pkg::IDX_NEG_LOW, 32'h0C);
      // Error tally: 300 events, manual update, read-only high byte
      @(posedge clk);
      ev <= 1'b1;
      repeat (300) @(posedge clk);
      ev <= 1'b0;
      wr(jpm_pkg::IDX_TALLY_CTRL, 32'h1);
      rd(jpm_pkg::IDX_ERR_LOW, 32'h2C);
      rd(jpm_pkg::IDX_ERR_HIGH, 32'h01);
      wr(jpm_pkg::IDX_ERR_HIGH, 32'hFF);
      rd(jpm_pkg::IDX_ERR_HIGH, 32'h01);
      wr(jpm_pkg::IDX_TALLY_CTRL, 32'h0);
      // Overflow after 65536 events: flag, mask, clear
      @(posedge clk);
      ev <= 1'b1;
      repeat (65536) @(posedge clk);
      ev <= 1'b0;
      repeat (3) @(posedge clk);
      rd(jpm_pkg::IDX_TALLY_STAT, 32'h01);
      chk_bit(irq, 1'b0);
      wr(jpm_pkg::IDX_TALLY_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk_bit(irq, 1'b1);
      wr(jpm_pkg::IDX_TALLY_STAT, 32'h1);
      rd(jpm_pkg::IDX_TALLY_STAT, 32'h00);
      chk_bit(irq, 1'b0);
      // Automatic tally: result follows the one-second timebase
      wr(jpm_pkg::IDX_TALLY_CTRL, 32'h2);
      wait_pe(n);
      @(posedge clk);
      ev <= 1'b1;
      repeat (5) @(posedge clk);
      ev <= 1'b0;
      wait_pe(n);
      rd(jpm_pkg::IDX_ERR_LOW, 32'h05);
      rd(jpm_pkg::IDX_ERR_HIGH, 32'h00);
      // Unmapped and misaligned accesses are refused
      apb(1'b0, 11'h100, 2'h0, 32'h0, r, e);
      chk_reg(r, 32'h0);
      chk_bit(e, 1'b1);
      apb(1'b1, jpm_pkg::IDX_JM_CFG, 2'h1, 32'h1, r, e);
      chk_bit(e, 1'b1);
      rd(jpm_pkg::IDX_JM_CFG, 32'h06);
      end_sim();
   end
endmodule : jpm_top_bench
`default_nettype wire
